/* File: common/aisc_pkg.sv */
// Package of constants and carrier types for the analog port signal configuration
package aisc_pkg;
	// Range select encoding
	localparam logic RANGE_5V = 1'b0;
	localparam logic RANGE_10V = 1'b1;
	localparam logic [3:0] RANGE_5V_REF = 4'h5;
	localparam logic [3:0] RANGE_10V_REF = 4'hA;
	// Standby polarity and action encodings
	localparam logic POL_NORMAL = 1'b0;
	localparam logic POL_INVERTED = 1'b1;
	localparam logic ACT_OFF_ONLY = 1'b0;
	localparam logic ACT_OFF_ON = 1'b1;
	// First alarm pin select: bit 0 overtemperature, bit 1 power fail
	localparam logic [1:0] A1_OT = 2'h1;
	localparam logic [1:0] A1_PF = 2'h2;
	localparam logic [1:0] A1_BOTH = 2'h3;
	// Second alarm pin select: bit 0 overvoltage, bit 1 overcurrent, bit 2 overpower
	localparam logic [2:0] A2_OVP = 3'h1;
	localparam logic [2:0] A2_ALL = 3'h7;
	// Status pin select
	localparam logic ST_CV = 1'b0;
	localparam logic ST_DC = 1'b1;
	// Reset defaults
	localparam logic RST_RANGE = RANGE_10V;
	localparam logic RST_POL = POL_NORMAL;
	localparam logic RST_ACT = ACT_OFF_ONLY;
	localparam logic [1:0] RST_A1 = A1_BOTH;
	localparam logic [2:0] RST_A2 = A2_OVP;
	localparam logic RST_ST = ST_CV;

	typedef struct packed {
		logic range_sel;
		logic sb_polarity;
		logic sb_action;
		logic [1:0] alarm1_sel;
		logic [2:0] alarm2_sel;
		logic status_sel;
	} aisc_cfg_t;

	typedef struct packed {
		logic overtemperature_alarm;
		logic power_fail_alarm;
		logic overvoltage_alarm;
		logic overcurrent_alarm;
		logic overpower_alarm;
	} aisc_alarm_t;

	typedef struct packed {
		logic alarm1;
		logic alarm2;
		logic status;
		logic [3:0] ref_volts;
		logic range_10v;
	} aisc_pins_t;
endpackage : aisc_pkg

/* File: src/aisc_pin_map.sv */
// Alarm and status pin selection logic, registered outputs
`timescale 1ns/1ps
module aisc_pin_map (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Configuration and flags
	input aisc_pkg::aisc_cfg_t cfg_i,
	input aisc_pkg::aisc_alarm_t alarm_i,
	input wire logic constant_voltage_regulation_i,
	input wire logic dc_on_i,
	// Pins
	output aisc_pkg::aisc_pins_t pins_o
);
	import aisc_pkg::*;

	typedef struct packed {
		aisc_pins_t pins;
	} aisc_map_state_t;

	aisc_map_state_t state_r;
	aisc_map_state_t state_nxt;

	always_comb begin
		state_nxt = state_r;
		state_nxt.pins.alarm1 = (cfg_i.alarm1_sel[0] & alarm_i.overtemperature_alarm) |
			(cfg_i.alarm1_sel[1] & alarm_i.power_fail_alarm);
		state_nxt.pins.alarm2 = (cfg_i.alarm2_sel[0] & alarm_i.overvoltage_alarm) |
			(cfg_i.alarm2_sel[1] & alarm_i.overcurrent_alarm) |
			(cfg_i.alarm2_sel[2] & alarm_i.overpower_alarm);
		state_nxt.pins.status = (cfg_i.status_sel == ST_DC) ? dc_on_i :
			constant_voltage_regulation_i;
		state_nxt.pins.range_10v = cfg_i.range_sel;
		state_nxt.pins.ref_volts = (cfg_i.range_sel == RANGE_10V) ? RANGE_10V_REF : RANGE_5V_REF;
	end

	// Recomputed every cycle so a selection change shows on the next edge
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign pins_o = state_r.pins;
endmodule : aisc_pin_map

/* File: src/aisc_top.sv */
// Analog port signal configuration: settings, standby input handling, pin mapping
// Functional notes
// - Range selects 5 V or 10 V reference.
// - Standby polarity normal or inverted.
// - Standby action applies only outside analog remote.
// - Off-only action: standby can only switch off.
// - Off-on action: restore only if enabled elsewhere.
// - Alarm pin one: OT, PF, or either.
// - Alarm pin two: seven combos, default overvoltage.
// - Alarm pin two ORs selected alarms.
// - Status pin defaults to constant-voltage indication.
// - Status pin may show DC output state.
`timescale 1ns/1ps
module aisc_top (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Configuration write
	input wire logic cfg_we_i,
	input aisc_pkg::aisc_cfg_t cfg_i,
	// Device flags
	input aisc_pkg::aisc_alarm_t alarm_i,
	input wire logic constant_voltage_regulation_i,
	input wire logic analog_remote_active_i,
	// DC output control from other locations
	input wire logic dc_on_req_i,
	input wire logic dc_off_req_i,
	// Standby pin
	input wire logic remote_standby_input_i,
	// Outputs
	output aisc_pkg::aisc_cfg_t cfg_o,
	output wire logic dc_on_o,
	output wire logic standby_active_o,
	output aisc_pkg::aisc_pins_t pins_o
);
	import aisc_pkg::*;

	typedef struct packed {
		aisc_cfg_t cfg;
		logic dc_on;
		logic dc_wanted;
		logic sb_active;
	} aisc_state_t;

	aisc_state_t state_r;
	aisc_state_t state_nxt;
	logic sb_level;

	always_comb begin
		state_nxt = state_r;
		if (cfg_we_i) begin
			state_nxt.cfg = cfg_i;
			// Zero selection would leave a pin dead; keep previous instead
			if (cfg_i.alarm1_sel == 2'h0) begin
				state_nxt.cfg.alarm1_sel = state_r.cfg.alarm1_sel;
			end
			if (cfg_i.alarm2_sel == 3'h0) begin
				state_nxt.cfg.alarm2_sel = state_r.cfg.alarm2_sel;
			end
		end
		// Inverted mode flips the level sense of the pin
		sb_level = remote_standby_input_i ^ (state_r.cfg.sb_polarity == POL_INVERTED);
		state_nxt.sb_active = sb_level;
		if (dc_off_req_i) begin
			state_nxt.dc_on = 1'b0;
			state_nxt.dc_wanted = 1'b0;
		end else if (dc_on_req_i) begin
			state_nxt.dc_wanted = 1'b1;
			state_nxt.dc_on = !(sb_level && !analog_remote_active_i);
		end
		if (!analog_remote_active_i) begin
			if (sb_level) begin
				state_nxt.dc_on = 1'b0;
			end else if (state_r.sb_active && state_r.cfg.sb_action == ACT_OFF_ON &&
				state_nxt.dc_wanted) begin
				state_nxt.dc_on = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_r.cfg.range_sel <= RST_RANGE;
			state_r.cfg.sb_polarity <= RST_POL;
			state_r.cfg.sb_action <= RST_ACT;
			state_r.cfg.alarm1_sel <= RST_A1;
			state_r.cfg.alarm2_sel <= RST_A2;
			state_r.cfg.status_sel <= RST_ST;
			state_r.dc_on <= 1'b0;
			state_r.dc_wanted <= 1'b0;
			state_r.sb_active <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	aisc_pin_map u_pin_map (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.cfg_i(state_r.cfg),
		.alarm_i(alarm_i),
		.constant_voltage_regulation_i(constant_voltage_regulation_i),
		.dc_on_i(state_r.dc_on),
		.pins_o(pins_o)
	);

	assign cfg_o = state_r.cfg;
	assign dc_on_o = state_r.dc_on;
	assign standby_active_o = state_r.sb_active;
endmodule : aisc_top

/* File: test/aisc_ctrl_eq.sv */
// Control equipment model driving the standby pin
`timescale 1ns/1ps
module aisc_ctrl_eq (
	input wire logic clk_sys_i, inv_i, sb_req_i,
	output logic sb_pin_o
);
	// Level follows the polarity the device expects
	always_ff @(posedge clk_sys_i) sb_pin_o <= sb_req_i ^ inv_i;
endmodule : aisc_ctrl_eq

/* File: test/aisc_top_chk.sv */
// Assertions for the analog port signal configuration block
`timescale 1ns/1ps
module aisc_top_chk
	import aisc_pkg::*;
(
	input wire logic clk_sys_i, rst_i, cfg_we_i, constant_voltage_regulation_i,
	input wire logic analog_remote_active_i, dc_on_req_i, dc_off_req_i, dc_on_o,
	input wire logic remote_standby_input_i, standby_active_o,
	input aisc_cfg_t cfg_i, cfg_o,
	input aisc_alarm_t alarm_i,
	input aisc_pins_t pins_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic live_r;
	wire logic [1:0] a1 = {alarm_i.power_fail_alarm, alarm_i.overtemperature_alarm};
	wire logic [2:0] a2 = {alarm_i.overpower_alarm, alarm_i.overcurrent_alarm,
		alarm_i.overvoltage_alarm};
	wire logic sbn = remote_standby_input_i ^ cfg_o.sb_polarity;
	// Pins lag reset release by one edge, so checks wait for it
	always_ff @(posedge clk_sys_i or posedge rst_i) live_r <= !rst_i;
	chk_alarm1_or:
	assert property (live_r |-> pins_o.alarm1 == |($past(cfg_o.alarm1_sel) & $past(a1)))
		else $error("alarm1 pin");
	chk_alarm2_or:
	assert property (live_r |-> pins_o.alarm2 == |($past(cfg_o.alarm2_sel) & $past(a2)))
		else $error("alarm2 pin");
	chk_status_src:
	assert property (live_r |-> pins_o.status == ($past(cfg_o.status_sel) ?
		$past(dc_on_o) : $past(constant_voltage_regulation_i))) else $error("status pin");
	chk_cfg_load:
	assert property (cfg_we_i && cfg_i.alarm1_sel != 0 && cfg_i.alarm2_sel != 0 |=>
		cfg_o == $past(cfg_i)) else $error("cfg load");
	chk_reset_dflt:
	assert property ($past(rst_i) |-> cfg_o == {RST_RANGE, RST_POL, RST_ACT, RST_A1,
		RST_A2, RST_ST}) else $error("cfg default");
	chk_sb_polarity:
	assert property (live_r |-> standby_active_o == $past(sbn)) else $error("polarity");
	chk_sb_off:
	assert property (live_r && $past(sbn) && !$past(analog_remote_active_i) |-> !dc_on_o)
		else $error("standby off");
	chk_offonly_on:
	assert property ($rose(dc_on_o) && $past(cfg_o.sb_action) == ACT_OFF_ONLY |->
		$past(dc_on_req_i)) else $error("off only");
	cover property (pins_o.alarm2 && cfg_o.alarm2_sel == A2_ALL);
	cover property ($rose(dc_on_o) && $fell(standby_active_o));
	cover property (pins_o.status && cfg_o.status_sel == ST_DC);
endmodule : aisc_top_chk
bind aisc_top aisc_top_chk chk_i (.*);

/* File: test/test_aisc_top.sv */
// Self-checking bench for the analog port signal configuration block
`timescale 1ns/1ps
module test_aisc_top;
	import aisc_pkg::*;
	logic clk_sys_i = 0, rst_i = 1, we = 0, cv = 0, rem = 0, on = 0, off = 0, sb = 0;
	logic dc, sba, pin;
	logic [8:0] e;
	aisc_cfg_t c, cfg = '0, cfg_o;
	aisc_alarm_t al = '0;
	aisc_pins_t pins;
	int num_errors = 0, compares = 0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	aisc_ctrl_eq eq (.clk_sys_i, .inv_i(cfg.sb_polarity), .sb_req_i(sb), .sb_pin_o(pin));
	aisc_top dut (.clk_sys_i, .rst_i, .cfg_we_i(we), .cfg_i(cfg), .alarm_i(al),
		.constant_voltage_regulation_i(cv), .analog_remote_active_i(rem), .dc_on_req_i(on),
		.dc_off_req_i(off), .remote_standby_input_i(pin), .cfg_o, .dc_on_o(dc),
		.standby_active_o(sba), .pins_o(pins));
	task automatic cyc(int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : cyc
	task automatic chk(string s, logic [8:0] x, logic [8:0] g);
		compares++;
		if (g !== x) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", s, x, g);
		end
	endtask : chk
	task automatic wr(aisc_cfg_t v);
		cfg <= v;
		we <= 1'b1;
		cyc(1);
		we <= 1'b0;
		cyc(2);
	endtask : wr
	task automatic req(logic o);
		{on, off} <= {o, !o};
		cyc(1);
		{on, off} <= 2'h0;
		cyc(2);
	endtask : req
	// Status pin is set to DC state, so it must follow dc_on_o
	task automatic sbt(logic v, logic x);
		sb <= v;
		cyc(4);
		chk("standby", v, sba);
		chk("dc_on", x, dc);
		chk("status", x, pins.status);
	endtask : sbt
	task automatic finish_test();
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	initial begin
		cyc(3);
		rst_i <= 1'b0;
		cyc(1);
		chk("cfg_rst", {RST_RANGE, RST_POL, RST_ACT, RST_A1, RST_A2, RST_ST}, cfg_o);
		for (int s = 1; s < 8; s++) begin
			c = '{s[0], POL_NORMAL, ACT_OFF_ONLY, 2'(s % 3 + 1), 3'(s), s[1]};
			wr(c);
			for (int a = 0; a < 32; a++) begin
				al <= 5'(a);
				cv <= a[0];
				cyc(2);
				e = {|(c.alarm1_sel & {a[3], a[4]}), |(c.alarm2_sel & {a[0], a[1], a[2]}),
					!s[1] & a[0], s[0] ? RANGE_10V_REF : RANGE_5V_REF, s[0]};
				chk("pins", e, pins);
			end
		end
		e = c;
		// Zero selections are refused field by field; the range still loads
		c.alarm1_sel = 2'h0;
		c.alarm2_sel = 3'h0;
		c.range_sel = RANGE_5V;
		e[8] = RANGE_5V;
		wr(c);
		chk("cfg_keep", e, cfg_o);
		c = '{RANGE_5V, POL_INVERTED, ACT_OFF_ON, A1_OT, A2_ALL, ST_DC};
		wr(c);
		req(1'b1);
		sbt(1'b0, 1'b1);
		sbt(1'b1, 1'b0);
		sbt(1'b0, 1'b1);
		sbt(1'b1, 1'b0);
		req(1'b0);
		sbt(1'b0, 1'b0);
		c.sb_action = ACT_OFF_ONLY;
		c.sb_polarity = POL_NORMAL;
		wr(c);
		req(1'b1);
		sbt(1'b1, 1'b0);
		sbt(1'b0, 1'b0);
		rem <= 1'b1;
		req(1'b1);
		sbt(1'b1, 1'b1);
		finish_test();
	end
endmodule : test_aisc_top
